// File: src/mcg_block.sv
// one logic block: allocator, macrocells, block clock generator, apb config
`include "mcg_defs.svh"

// Summary of operation
// - macrocell n steers clusters n-1..n+2, clipped at both ends
// - small variant splits allocator into two halves of eight
// - mode of macrocell n selects how cluster n is formed
// - storage is d register, t register, d latch or combinatorial
// - d loads on active edge; t toggles on active edge when t is 1
// - latch passes d while enable low, holds while high; polarity inverts
// - clock or latch enable polarity selectable per macrocell
// - xor gate lets d or t storage emulate j-k or s-r
// - extra term feeds xor input; input polarity programmable
// - clock from four block clocks; async mode adds product term clock
// - sync mode uses block-shared reset and preset terms
// - swap exchanges reset and preset, including power-up state
// - async mode: one individual term initialises as reset or preset
// - reset gives 0, preset gives 1, both give 0
// - transparent latch ignores reset and preset
// - macrocell output goes to output matrix and feedback path
// - four global clock pins feed four block clocks
// - block clocks 0 and 1 take one of four pairs
// - block clocks 2 and 3 take one of four pairs
// - two-pin variants tie global two to zero, three to one
module mcg_block #(
  parameter int NUM_MC       = 16,
  parameter bit SMALL_ALLOC  = 1'b0,
  parameter bit TWO_CLK_PINS = 1'b0
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_arst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  input  wire logic              i_global_clock_zero,
  input  wire logic              i_global_clock_one,
  input  wire logic              i_global_clock_two,
  input  wire logic              i_global_clock_three,
  input  wire logic [NUM_MC-1:0] i_cluster_terms,
  input  wire logic [NUM_MC-1:0] i_cluster_alt,
  input  wire logic [NUM_MC-1:0] i_xor_term,
  input  wire logic [NUM_MC-1:0] i_pt_clock,
  input  wire logic [NUM_MC-1:0] i_pt_init,
  input  wire logic              i_async_reset_term,
  input  wire logic              i_async_preset_term,
  output logic [3:0]             o_block_clock,
  output logic [NUM_MC-1:0]      o_macrocell_out,
  output logic [NUM_MC-1:0]      o_feedback
);

  // ----------------------------------------------------------------
  // allocator reach
  // ----------------------------------------------------------------
  function automatic logic [3:0] alloc_allow(input int n);
    logic [3:0] m;
    int         c;
    m = 4'h0;
    for (int k = 0; k < `MCG_ALLOC_SPAN; k++) begin
      c = n - 1 + k;
      if (c >= 0 && c < NUM_MC) begin
        if (!SMALL_ALLOC || ((c >= NUM_MC / 2) == (n >= NUM_MC / 2))) begin
          m[k] = 1'b1;
        end
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // configuration, clock and macrocell state
  // ----------------------------------------------------------------
  logic                  run_ff;
  logic [3:0]            clkgen_ff;
  logic [`MCG_CFG_W-1:0] cfg_ff [NUM_MC];
  logic [3:0]            bclk_ff;
  logic [NUM_MC-1:0]     q_vec;
  logic [NUM_MC-1:0]     cl_val;
  logic [NUM_MC+2:0]     cl_pad;
  logic                  g2;
  logic                  g3;
  logic [3:0]            nxt_bclk;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        acc;
  logic        wr_fire;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_cgen;
  logic        hit_mc;
  logic [3:0]  mc_idx;
  logic [31:0] rd_val;
  logic        bad;

  assign acc      = i_psel & i_penable;
  assign wr_fire  = acc & pready_ff & i_pwrite & ~bad;
  assign hit_ctrl = (i_paddr == `MCG_ADDR_CTRL);
  assign hit_stat = (i_paddr == `MCG_ADDR_STATUS);
  assign hit_cgen = (i_paddr == `MCG_ADDR_CLKGEN);
  assign hit_mc   = (i_paddr[7:6] == `MCG_ADDR_MC_HI) && (i_paddr[1:0] == 2'h0)
                    && (32'(i_paddr[5:2]) < NUM_MC);
  assign mc_idx   = i_paddr[5:2];
  assign o_pready  = pready_ff;
  assign o_prdata  = prdata_ff;
  assign o_pslverr = pslverr_ff;

  always_comb begin
    rd_val = 32'h0000_0000;
    bad    = 1'b0;
    if (hit_ctrl) begin
      rd_val[`MCG_CTRL_RUN] = run_ff;
    end else if (hit_stat) begin
      rd_val[NUM_MC-1:0] = q_vec;
    end else if (hit_cgen) begin
      rd_val[3:0] = clkgen_ff;
      bad         = i_pwrite & run_ff;
    end else if (hit_mc) begin
      rd_val[`MCG_CFG_W-1:0] = cfg_ff[mc_idx];
      bad                    = i_pwrite & run_ff;
    end else begin
      bad = 1'b1;
    end
  end

  // one wait state: data is registered on the same edge as pready rises
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= acc & ~pready_ff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (acc && !pready_ff) begin
      prdata_ff  <= i_pwrite ? 32'h0000_0000 : rd_val;
      pslverr_ff <= bad;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_ff <= 1'b0;
    end else if (wr_fire && hit_ctrl) begin
      run_ff <= i_pwdata[`MCG_CTRL_RUN];
    end
  end

  // config only changes while stopped, so the macrocells never see it move; the block clocks follow clkgen one i_clk_sys cycle later
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clkgen_ff <= `MCG_CLKGEN_RST;
    end else if (wr_fire && hit_cgen) begin
      clkgen_ff <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NUM_MC; i++) begin
        cfg_ff[i] <= `MCG_CFG_RST;
      end
    end else if (wr_fire && hit_mc) begin
      cfg_ff[mc_idx] <= i_pwdata[`MCG_CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // block clock generator
  // ----------------------------------------------------------------
  assign g2 = TWO_CLK_PINS ? i_global_clock_zero : i_global_clock_two;
  assign g3 = TWO_CLK_PINS ? i_global_clock_one : i_global_clock_three;

  always_comb begin
    case (clkgen_ff[1:0])
      2'h0: nxt_bclk[1:0] = {i_global_clock_one, i_global_clock_zero};
      2'h1: nxt_bclk[1:0] = {i_global_clock_one, ~i_global_clock_one};
      2'h2: nxt_bclk[1:0] = {~i_global_clock_zero, i_global_clock_zero};
      default: nxt_bclk[1:0] = {~i_global_clock_zero, ~i_global_clock_one};
    endcase
    case (clkgen_ff[3:2])
      2'h0: nxt_bclk[3:2] = {g3, g2};
      2'h1: nxt_bclk[3:2] = {g3, ~g3};
      2'h2: nxt_bclk[3:2] = {~g2, g2};
      default: nxt_bclk[3:2] = {~g2, ~g3};
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bclk_ff <= 4'h0;
    end else begin
      bclk_ff <= nxt_bclk;
    end
  end

  assign o_block_clock = bclk_ff;

  // ----------------------------------------------------------------
  // clusters and macrocells
  // ----------------------------------------------------------------
  // async mode forms cluster n from i_cluster_alt instead of i_cluster_terms
  always_comb begin
    for (int c = 0; c < NUM_MC; c++) begin
      cl_val[c] = cfg_ff[c][`MCG_CFG_ASYNC] ? i_cluster_alt[c] : i_cluster_terms[c];
    end
  end

  assign cl_pad = {2'b00, cl_val, 1'b0};

  for (genvar n = 0; n < NUM_MC; n++) begin : g_mc
    localparam logic [3:0] ALLOW = alloc_allow(n);
    logic [`MCG_CFG_W-1:0] cfg;
    mcg_pkg::mcg_store_t   st;
    mcg_pkg::mcg_clksrc_t  cs;
    logic                  async_m;
    logic                  sum;
    logic                  d_in;
    logic                  src;
    logic                  clk_lvl;
    logic                  edge_hit;
    logic                  init_r;
    logic                  init_p;
    logic                  lvl_ff;
    logic                  q_ff;

    assign cfg     = cfg_ff[n];
    assign st      = mcg_pkg::mcg_store_t'(cfg[`MCG_CFG_ST_LSB +: 2]);
    assign cs      = mcg_pkg::mcg_clksrc_t'(cfg[`MCG_CFG_CS_LSB +: 3]);
    assign async_m = cfg[`MCG_CFG_ASYNC];
    assign sum     = |(cfg[`MCG_CFG_MASK_LSB +: 4] & ALLOW & cl_pad[n +: 4]);
    // xor with the extra term builds j-k / s-r; both polarities available
    assign d_in    = (cfg[`MCG_CFG_XOR] ? (sum ^ i_xor_term[n]) : sum)
                     ^ cfg[`MCG_CFG_INPOL];

    // --------------------------------------------------------------
    // clock or latch enable source
    // --------------------------------------------------------------
    always_comb begin
      case (cs)
        mcg_pkg::MCG_CS_BLK0: src = bclk_ff[0];
        mcg_pkg::MCG_CS_BLK1: src = bclk_ff[1];
        mcg_pkg::MCG_CS_BLK2: src = bclk_ff[2];
        mcg_pkg::MCG_CS_BLK3: src = bclk_ff[3];
        mcg_pkg::MCG_CS_PT:   src = async_m ? i_pt_clock[n] : bclk_ff[0];
        mcg_pkg::MCG_CS_PT_N: src = async_m ? ~i_pt_clock[n] : bclk_ff[0];
        default:              src = bclk_ff[0];
      endcase
    end

    assign clk_lvl  = src ^ cfg[`MCG_CFG_CLKPOL];
    assign edge_hit = clk_lvl & ~lvl_ff;

    // --------------------------------------------------------------
    // initialisation terms
    // --------------------------------------------------------------
    // terms act at the next edge; a glitch shorter than a cycle is lost
    always_comb begin
      if (async_m) begin
        init_r = i_pt_init[n] & ~cfg[`MCG_CFG_SWAP];
        init_p = i_pt_init[n] & cfg[`MCG_CFG_SWAP];
      end else if (cfg[`MCG_CFG_SWAP]) begin
        init_r = i_async_preset_term;
        init_p = i_async_reset_term;
      end else begin
        init_r = i_async_reset_term;
        init_p = i_async_preset_term;
      end
    end

    // --------------------------------------------------------------
    // edge detect
    // --------------------------------------------------------------
    // resets low whatever clock is selected, so only a clock idling low gives no false edge
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        lvl_ff <= 1'b0;
      end else begin
        lvl_ff <= clk_lvl;
      end
    end

    // --------------------------------------------------------------
    // storage element
    // --------------------------------------------------------------
    // while stopped each cell sits at its power-up value
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        q_ff <= 1'b0;
      end else if (!run_ff) begin
        q_ff <= cfg[`MCG_CFG_SWAP];
      end else begin
        case (st)
          mcg_pkg::MCG_COMB: q_ff <= d_in;
          mcg_pkg::MCG_D_LATCH: begin
            if (!clk_lvl) begin
              q_ff <= d_in;
            end
          end
          mcg_pkg::MCG_D_REG: begin
            if (init_r) begin
              q_ff <= 1'b0;
            end else if (init_p) begin
              q_ff <= 1'b1;
            end else if (edge_hit) begin
              q_ff <= d_in;
            end
          end
          mcg_pkg::MCG_T_REG: begin
            if (init_r) begin
              q_ff <= 1'b0;
            end else if (init_p) begin
              q_ff <= 1'b1;
            end else if (edge_hit && d_in) begin
              q_ff <= ~q_ff;
            end
          end
          default: q_ff <= q_ff;
        endcase
      end
    end

    assign q_vec[n] = q_ff;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_macrocell_out = q_vec;
  assign o_feedback      = q_vec;

endmodule

// File: src/mcg_defs.svh
// offsets, field positions, reset values and sizes of the macrocell clock block
`ifndef MCG_DEFS_SVH
`define MCG_DEFS_SVH
`define MCG_ADDR_CTRL    8'h00
`define MCG_ADDR_STATUS  8'h04
`define MCG_ADDR_CLKGEN  8'h08
`define MCG_ADDR_MC_HI   2'h1
`define MCG_CTRL_RUN     0
`define MCG_CFG_W        14
`define MCG_CFG_MASK_LSB 0
`define MCG_CFG_ST_LSB   4
`define MCG_CFG_ASYNC    6
`define MCG_CFG_XOR      7
`define MCG_CFG_INPOL    8
`define MCG_CFG_CS_LSB   9
`define MCG_CFG_CLKPOL   12
`define MCG_CFG_SWAP     13
`define MCG_CFG_RST      14'h0000
`define MCG_CLKGEN_RST   4'h0
`define MCG_ALLOC_SPAN   4
`endif

// File: src/mcg_pkg.sv
// types of the macrocell clock block
package mcg_pkg;
  typedef enum logic [1:0] {
    MCG_D_REG,
    MCG_T_REG,
    MCG_D_LATCH,
    MCG_COMB
  } mcg_store_t;
  typedef enum logic [2:0] {
    MCG_CS_BLK0,
    MCG_CS_BLK1,
    MCG_CS_BLK2,
    MCG_CS_BLK3,
    MCG_CS_PT,
    MCG_CS_PT_N
  } mcg_clksrc_t;
endpackage

// File: bench/mcg_block_chk.sv
// assertion checker for the macrocell clock block
module mcg_block_chk #(
  parameter int NUM_MC       = 16,
  parameter bit TWO_CLK_PINS = 1'b0
) (
  input wire logic              i_clk_sys,
  input wire logic              i_arst_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [7:0]        i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pslverr,
  input wire logic              i_global_clock_zero,
  input wire logic              i_global_clock_one,
  input wire logic              i_global_clock_two,
  input wire logic              i_global_clock_three,
  input wire logic [3:0]        o_block_clock,
  input wire logic [NUM_MC-1:0] o_macrocell_out,
  input wire logic [NUM_MC-1:0] o_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of run, clock pairs and swap bits; refused writes never land
  logic              run_ff;
  logic [3:0]        cg_ff;
  logic [NUM_MC-1:0] sw_ff;
  wire logic wr = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  wire logic lck = i_paddr == 8'h08 || i_paddr[7:6] == 2'h1;
  wire logic hit = i_paddr[1:0] == 2'h0 && (i_paddr <= 8'h08 || i_paddr[7:6] == 2'h1);
  // two-pin variants see global two and three as copies of zero and one
  wire logic c2 = TWO_CLK_PINS ? i_global_clock_zero : i_global_clock_two;
  wire logic c3 = TWO_CLK_PINS ? i_global_clock_one : i_global_clock_three;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_ff <= 1'b0;
      cg_ff  <= 4'h0;
      sw_ff  <= '0;
    end else if (wr) begin
      if (i_paddr == 8'h00) run_ff <= i_pwdata[0];
      if (i_paddr == 8'h08) cg_ff <= i_pwdata[3:0];
      if (i_paddr[7:6] == 2'h1) sw_ff[i_paddr[5:2]] <= i_pwdata[13];
    end
  end
  function automatic logic [1:0] pr(input logic [1:0] s, input logic a, input logic b);
    case (s)
      2'h0: pr = {b, a};
      2'h1: pr = {b, ~b};
      2'h2: pr = {~a, a};
      default: pr = {~a, ~b};
    endcase
  endfunction
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_acc1;
    i_psel && i_penable && !o_pready && !$past(i_penable);
  endsequence
  sequence s_done;
    o_pready ##1 !o_pready;
  endsequence
  a_pready_wait: assert property (s_acc1 |=> s_done) else $error("pready timing wrong");
  a_unmapped_err: assert property (o_pready && !hit |-> o_pslverr) else $error("no error");
  a_locked_write: assert property (
    o_pready && i_pwrite && run_ff && lck |-> o_pslverr) else $error("locked write taken");
  a_err_rdzero: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
    else $error("error read not zero");
  a_feedback_copy: assert property (o_feedback == o_macrocell_out)
    else $error("feedback differs");
  a_bclk_low: assert property (o_block_clock[1:0] == pr($past(cg_ff[1:0]),
    $past(i_global_clock_zero), $past(i_global_clock_one))) else $error("bclk 0/1 wrong");
  a_bclk_high: assert property (o_block_clock[3:2] == pr($past(cg_ff[3:2]),
    $past(c2), $past(c3))) else $error("bclk 2/3 wrong");
  a_idle_q: assert property (!$past(run_ff) |-> o_macrocell_out == $past(sw_ff))
    else $error("idle q not swap value");
endmodule
bind mcg_block mcg_block_chk #(.NUM_MC(NUM_MC), .TWO_CLK_PINS(TWO_CLK_PINS)) i_mcg_block_chk (
  .i_clk_sys, .i_arst_n,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
  .i_global_clock_zero, .i_global_clock_one, .i_global_clock_two, .i_global_clock_three,
  .o_block_clock, .o_macrocell_out, .o_feedback);

// File: bench/testbench.sv
// self-checking testbench for the macrocell clock block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_async_reset_term = 1'b0, i_async_preset_term = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
  logic [3:0]  g = 4'h0, o_block_clock;
  logic [15:0] i_cluster_terms = 16'h0000, o_macrocell_out, o_feedback, t, u;
  // async-mode inputs, driven by the async scenarios near the end
  logic [15:0] i_cluster_alt = 16'h0000, i_xor_term = 16'h0000;
  // second block: split allocator, two clock pins
  logic [3:0]  small_block_clock;
  logic [15:0] small_macrocell_out;
  logic [15:0] i_pt_clock = 16'h0000, i_pt_init = 16'h0000;
  logic        o_pready, o_pslverr, rerr;
  integer      seed = 32'h9df777d4;
  int          n_mismatch = 0, checks_done = 0;
  mcg_block i_mcg_block (.i_clk_sys, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_global_clock_zero(g[0]),
    .i_global_clock_one(g[1]), .i_global_clock_two(g[2]), .i_global_clock_three(g[3]),
    .i_cluster_terms, .i_cluster_alt, .i_xor_term, .i_pt_clock, .i_pt_init,
    .i_async_reset_term, .i_async_preset_term, .o_block_clock, .o_macrocell_out,
    .o_feedback);
  mcg_block #(.SMALL_ALLOC(1'b1), .TWO_CLK_PINS(1'b1)) i_mcg_block_small (.i_clk_sys,
    .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready(), .o_prdata(),
    .o_pslverr(), .i_global_clock_zero(g[0]), .i_global_clock_one(g[1]),
    .i_global_clock_two(g[2]), .i_global_clock_three(g[3]), .i_cluster_terms, .i_cluster_alt,
    .i_xor_term, .i_pt_clock, .i_pt_init, .i_async_reset_term, .i_async_preset_term,
    .o_block_clock(small_block_clock), .o_macrocell_out(small_macrocell_out),
    .o_feedback());
  always #5 i_clk_sys = ~i_clk_sys;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // idle edge after release so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    // no fixed wait assumed; the watchdog bounds a hang
    do begin
      @(posedge i_clk_sys);
    end while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic cfg_all(input logic [31:0] c);
    apb(1'b1, 8'h00, 32'h0);
    for (int n = 0; n < 16; n++) apb(1'b1, 8'(8'h40 + 4 * n), c);
    apb(1'b1, 8'h00, 32'h1);
  endtask
  task automatic pulse;
    g[0] <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    g[0] <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask
  task automatic wait3;
    repeat (3) @(posedge i_clk_sys);
  endtask
  function automatic logic [1:0] f_pair(input logic [1:0] s, input logic a, input logic b);
    case (s)
      2'h0: f_pair = {b, a};
      2'h1: f_pair = {b, ~b};
      2'h2: f_pair = {~a, a};
      default: f_pair = {~a, ~b};
    endcase
  endfunction
  function automatic logic [3:0] f_bclk(input logic [3:0] s, input logic [3:0] gp, input bit two);
    if (two) begin
      f_bclk = {f_pair(s[3:2], gp[0], gp[1]), f_pair(s[1:0], gp[0], gp[1])};
    end else begin
      f_bclk = {f_pair(s[3:2], gp[2], gp[3]), f_pair(s[1:0], gp[0], gp[1])};
    end
  endfunction
  // split allocator keeps each macrocell inside its own half of eight
  function automatic logic [15:0] f_alloc(input logic [15:0] c, input int k, input bit sm);
    f_alloc = 16'h0000;
    for (int n = 0; n < 16; n++) begin
      if (n - 1 + k >= 0 && n - 1 + k <= 15 && (!sm || ((n - 1 + k >= 8) == (n >= 8)))) begin
        f_alloc[n] = c[n - 1 + k];
      end
    end
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #100us;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    @(posedge i_clk_sys);
    apb(1'b0, 8'h08, 32'h0);
    chk("clkgen reset", rdat, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped error", rerr, 32'h1);
    for (int s = 0; s < 16; s++) begin
      apb(1'b1, 8'h08, 32'(s));
      repeat (4) begin
        g <= 4'($random(seed));
        repeat (2) @(posedge i_clk_sys);
        chk("bclk", o_block_clock, f_bclk(4'(s), g, 1'b0));
        chk("bclk two pins", small_block_clock, f_bclk(4'(s), g, 1'b1));
      end
    end
    apb(1'b1, 8'h08, 32'h0);
    g <= 4'h0;
    for (int k = 0; k < 4; k++) begin
      cfg_all(32'h1 << k);
      i_cluster_terms <= 16'($random(seed));
      pulse();
      chk("alloc", o_macrocell_out, f_alloc(i_cluster_terms, k, 1'b0));
      chk("alloc small", small_macrocell_out, f_alloc(i_cluster_terms, k, 1'b1));
      apb(1'b0, 8'h04, 32'h0);
      chk("status", rdat, {16'h0000, f_alloc(i_cluster_terms, k, 1'b0)});
    end
    apb(1'b1, 8'h08, 32'h5);
    chk("locked write", rerr, 32'h1);
    cfg_all(32'h12);
    t = 16'($random(seed));
    u = 16'($random(seed));
    i_cluster_terms <= t;
    pulse();
    i_cluster_terms <= u;
    wait3();
    pulse();
    chk("t toggle", o_macrocell_out, t ^ u);
    cfg_all(32'h2);
    i_async_preset_term <= 1'b1;
    wait3();
    chk("preset", o_macrocell_out, 16'hFFFF);
    i_async_reset_term <= 1'b1;
    wait3();
    chk("both", o_macrocell_out, 16'h0000);
    i_async_preset_term <= 1'b0;
    cfg_all(32'h2002);
    chk("swap", o_macrocell_out, 16'hFFFF);
    cfg_all(32'h22);
    i_cluster_terms <= t;
    wait3();
    chk("latch open", o_macrocell_out, t);
    g[0] <= 1'b1;
    wait3();
    i_cluster_terms <= u;
    wait3();
    chk("latch hold", o_macrocell_out, t);
    // async mode: alternate sum, xor term, product-term clock and init
    i_cluster_alt <= t;
    i_xor_term <= u;
    cfg_all(32'h08C2);
    i_pt_clock <= 16'hFFFF;
    wait3();
    chk("async xor", o_macrocell_out, t ^ u);
    i_pt_init <= 16'h00FF;
    wait3();
    chk("async init", o_macrocell_out, (t ^ u) & 16'hFF00);
    i_pt_init <= 16'h0000;
    i_pt_clock <= 16'h0000;
    cfg_all(32'h0B42);
    i_pt_clock <= 16'hFFFF;
    wait3();
    i_pt_clock <= 16'h0000;
    wait3();
    chk("async inverted clock", o_macrocell_out, 16'(~t));
    conclude();
  end
endmodule
